// file: bench/rpu_rom_model.sv
`timescale 1ns/1ns
// rom controller stand-in: data phase word is a fixed scramble of the captured address
module rpu_rom_model (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [31:0] haddr_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hready_i,
  output logic [31:0] rdata_o
);
  logic [31:0] addr_reg;
  logic act_reg;
  logic [31:0] junk_reg;
  // same bus clock
  // idle data bus churns so a stale word never passes for a good one
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_reg <= 32'h0;
      act_reg <= 1'b0;
      junk_reg <= 32'h1357_9bdf;
    end else begin
      act_reg <= hsel_i & htrans_i[1] & hready_i;
      addr_reg <= haddr_i;
      junk_reg <= junk_reg + 32'h0101_0101;
    end
  end
  assign rdata_o = act_reg ? (addr_reg ^ 32'ha5a5_0000) : junk_reg;
endmodule

// file: bench/test_rpu_top.sv
`timescale 1ns/1ns
module test_rpu_top;
  import rpu_pkg::*;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] raddr = 32'h0;
  logic rsel = 1'b0;
  logic [1:0] rtrans = 2'b00;
  logic rready = 1'b1;
  logic [31:0] hrdata, rom_d, rdata, rd;
  logic hrdy;
  logic [1:0] hresp, rs;
  logic [7:0] vflags;
  int failures = 0;
  int checks_done = 0;
  // clock and dut wiring; single slave so bus ready is our own readyout
  always #2 core_clk_i = ~core_clk_i;
  rpu_top dut_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .rom_haddr_i(raddr), .rom_hsel_i(rsel),
    .rom_htrans_i(rtrans), .rom_hready_i(rready), .rom_rdata_i(rom_d), .rom_rdata_o(rdata),
    .valid_flags_o(vflags));
  rpu_rom_model rom_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .haddr_i(raddr), .hsel_i(rsel),
    .htrans_i(rtrans), .hready_i(rready), .rdata_o(rom_d));
  // verdict and end of run
  task automatic final_report;
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // one config access, idle cycle before it; response taken at the edge readyout is high
  task automatic xfer(input logic wr, input logic [9:0] ofs, input logic [31:0] wd, input logic [2:0] sz);
    int n;
    @(posedge core_clk_i);
    hsel <= 1'b1;
    haddr <= RPU_REG_BASE + {22'h0, ofs};
    htrans <= RPU_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    @(posedge core_clk_i);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (hrdy !== 1'b1 && n < 8);
    rd = hrdata;
    rs = hresp;
    if (hrdy !== 1'b1) begin
      failures++;
      final_report();
    end
  endtask
  task automatic wr(input logic [9:0] ofs, input logic [31:0] wd);
    xfer(1'b1, ofs, wd, 3'h2);
  endtask
  task automatic rdc(input string what, input logic [9:0] ofs, input logic [31:0] exp);
    xfer(1'b0, ofs, 32'h0, 3'h2);
    chk(what, {RPU_HRESP_OKAY, exp}, {rs, rd});
  endtask
  task automatic vchk(input logic [7:0] exp);
    @(posedge core_clk_i);
    chk("valid flags", {26'h0, exp}, {26'h0, vflags});
  endtask
  // rom read: address phase, then data phase compared at its closing edge
  task automatic romrd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    raddr <= a;
    rsel <= 1'b1;
    rtrans <= RPU_HTRANS_NONSEQ;
    @(posedge core_clk_i);
    rsel <= 1'b0;
    rtrans <= 2'b00;
    raddr <= ~a;
    @(posedge core_clk_i);
    chk("rom data", {2'b00, exp}, {2'b00, rdata});
  endtask
  // entry 6 shares entry 1's word; entry 0 sits on the last rom word, entry 7 just past it
  function automatic logic [31:0] ent_addr(input int n);
    if (n == 0) return 32'h0001_4ffc;
    if (n == 6) return 32'h0000_0104;
    if (n == 7) return 32'h0001_5000;
    return 32'h0000_0100 + 32'(4 * n);
  endfunction
  function automatic logic [31:0] ent_data(input int n);
    return {24'hd0d0d0, 8'(n)};
  endfunction
  initial begin
    repeat (8) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    vchk(8'h00);
    rdc("valid reg", RPU_OFS_VALID, 32'h0);
    for (int n = 0; n < 8; n++) begin
      wr(10'(8 * n), ent_addr(n));
      chk("valid early", 34'h0, {33'h0, vflags[n]});
      wr(10'(8 * n + 4), ent_data(n));
      @(posedge core_clk_i);
      chk("valid set", 34'h1, {33'h0, vflags[n]});
    end
    for (int n = 0; n < 8; n++) begin
      rdc("match addr", 10'(8 * n), ent_addr(n));
      rdc("repl word", 10'(8 * n + 4), ent_data(n));
    end
    for (int n = 0; n < 6; n++) romrd(ent_addr(n), ent_data(n == 1 ? 6 : n));
    romrd(32'h0000_0106, ent_data(6));
    romrd(32'h0000_0118, 32'h0000_0118 ^ 32'ha5a5_0000);
    romrd(32'h0001_5000, 32'h0001_5000 ^ 32'ha5a5_0000);
    wr(RPU_OFS_CLEAR, 32'h0000_0040);
    vchk(8'hbf);
    romrd(32'h0000_0104, ent_data(1));
    wr(RPU_OFS_CLEAR, 32'h0);
    wr(RPU_OFS_SET, 32'h0);
    vchk(8'hbf);
    wr(10'h034, 32'hbeef_0006);
    vchk(8'hbf);
    wr(RPU_OFS_SET, 32'h0000_0040);
    vchk(8'hff);
    romrd(32'h0000_0104, 32'hbeef_0006);
    xfer(1'b0, 10'h04c, 32'h0, 3'h2);
    chk("unmapped resp", {32'h0, RPU_HRESP_ERROR}, {32'h0, rs});
    xfer(1'b1, 10'h004, 32'hffff_ffff, 3'h0);
    chk("byte write resp", {32'h0, RPU_HRESP_ERROR}, {32'h0, rs});
    rdc("after bad write", 10'h004, ent_data(0));
    rdc("clear reads zero", RPU_OFS_CLEAR, 32'h0);
    wr(RPU_OFS_VALID, 32'h0);
    vchk(8'hff);
    wr(10'h038, 32'h0000_0104);
    wr(10'h03c, 32'hc0de_0007);
    romrd(32'h0000_0104, 32'hc0de_0007);
    @(posedge core_clk_i);
    rready <= 1'b0;
    @(posedge core_clk_i);
    rready <= 1'b1;
    romrd(32'h0000_0104, 32'hc0de_0007);
    final_report();
  end
endmodule

// file: design/rpu_entry_mem.sv
`timescale 1ns/1ns
// entry storage: one address word and one data word per entry
module rpu_entry_mem #(
  parameter int ENTRIES = 8,
  parameter int W = 32
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic wr_data_sel_i,
  input wire logic [2:0] wr_idx_i,
  input wire logic [W-1:0] wr_word_i,
  input wire logic rd_data_sel_i,
  input wire logic [2:0] rd_idx_i,
  output logic [W-1:0] rd_word_o,
  output logic [ENTRIES*W-1:0] addr_flat_o,
  output logic [ENTRIES*W-1:0] data_flat_o
);
  logic [W-1:0] addr_reg [ENTRIES];
  logic [W-1:0] data_reg [ENTRIES];

  // per-entry word pair, flattened for parallel compare
  for (genvar g = 0; g < ENTRIES; g++) begin : g_ent
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        addr_reg[g] <= '0;
        data_reg[g] <= '0;
      end else if (wr_en_i && wr_idx_i == 3'(g)) begin
        if (wr_data_sel_i) begin
          data_reg[g] <= wr_word_i;
        end else begin
          addr_reg[g] <= wr_word_i;
        end
      end
    end
    assign addr_flat_o[g*W +: W] = addr_reg[g];
    assign data_flat_o[g*W +: W] = data_reg[g];
  end

  // registered read port; a write landing on the same edge is forwarded,
  // so a read right behind a write to the same word sees the new value
  wire rd_hits_wr = wr_en_i && (wr_idx_i == rd_idx_i) && (wr_data_sel_i == rd_data_sel_i);
  wire [W-1:0] rd_stored = rd_data_sel_i ? data_reg[rd_idx_i] : addr_reg[rd_idx_i];
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_word_o <= '0;
    end else begin
      rd_word_o <= rd_hits_wr ? wr_word_i : rd_stored;
    end
  end
endmodule

// file: design/rpu_pkg.sv
package rpu_pkg;
  localparam int RPU_ENTRIES = 8;
  localparam int RPU_AW = 32;
  localparam int RPU_DW = 32;
  // register region base and last byte
  localparam logic [31:0] RPU_REG_BASE = 32'h4000_8400;
  localparam logic [31:0] RPU_REG_LAST = 32'h4000_87ff;
  // patchable rom region
  localparam logic [31:0] RPU_ROM_BASE = 32'h0000_0000;
  localparam logic [31:0] RPU_ROM_LAST = 32'h0001_4fff;
  // word offsets inside the register region: pairs then control words
  localparam logic [9:0] RPU_OFS_PAIR0 = 10'h000;
  localparam logic [9:0] RPU_OFS_VALID = 10'h040;
  localparam logic [9:0] RPU_OFS_CLEAR = 10'h044;
  localparam logic [9:0] RPU_OFS_SET = 10'h048;
  localparam logic [7:0] RPU_VALID_RST = 8'h00;
  localparam logic [1:0] RPU_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] RPU_HTRANS_SEQ = 2'b11;
  localparam logic [1:0] RPU_HRESP_OKAY = 2'b00;
  localparam logic [1:0] RPU_HRESP_ERROR = 2'b01;
  typedef enum logic [2:0] {
    RPU_ST_IDLE = 3'b001,
    RPU_ST_ERR1 = 3'b010,
    RPU_ST_ERR2 = 3'b100
  } rpu_state_t;
endpackage

// file: design/rpu_top.sv
`timescale 1ns/1ns
// Function
// RL1: the unit is a mux on the rom read data bus that can put patch words in place of rom data.
// RL2: there are eight entries, each a 32-bit match address paired with a 32-bit replacement word.
// RL3: software writes an entry's match address before its replacement word.
// RL4: once both words of an entry are written, its valid bit sets by itself.
// RL5: the bus address is compared against all eight entry addresses at once.
// RL6: an enabled matching entry's word replaces the rom data on the read bus.
// RL7: among several matching entries the highest number wins, seven over zero.
// RL8: a one in bit x of the write-only clear word disables entry x.
// RL9: a one in bit x of the write-only set word re-enables entry x.
// RL10: the unit runs on the bus clock and software reloads all entries after power-up.
// RL11: configuration registers answer as an ahb slave in 0x40008400 to 0x400087ff.
// RL12: software picks a free entry and weighs priority when two entries share an address.
// RL13: patching applies only to rom reads in 0x00000000 to 0x00014fff.
// RL14: with no enabled match, rom data passes unchanged with no added wait.
// RL15: valid bits clear at reset, and zero writes to set or clear words change nothing.
module rpu_top #(
  parameter int ENTRIES = rpu_pkg::RPU_ENTRIES
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // ahb-lite slave port for configuration
  input wire logic hsel_i,
  input wire logic [rpu_pkg::RPU_AW-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [rpu_pkg::RPU_DW-1:0] hwdata_i,
  input wire logic hready_i,
  output logic [rpu_pkg::RPU_DW-1:0] hrdata_o,
  output logic hreadyout_o,
  output logic [1:0] hresp_o,
  // rom data path: address phase seen on the system bus, data from rom controller
  input wire logic [rpu_pkg::RPU_AW-1:0] rom_haddr_i,
  input wire logic rom_hsel_i,
  input wire logic [1:0] rom_htrans_i,
  input wire logic rom_hready_i,
  input wire logic [rpu_pkg::RPU_DW-1:0] rom_rdata_i,
  output logic [rpu_pkg::RPU_DW-1:0] rom_rdata_o,
  output logic [7:0] valid_flags_o
);
  import rpu_pkg::*;

  // bit vector to highest set index, used only for match selection
  function automatic logic [2:0] top_index(input logic [7:0] v);
    top_index = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        top_index = 3'(i);
      end
    end
  endfunction

  function automatic logic is_active(input logic [1:0] t);
    is_active = (t == RPU_HTRANS_NONSEQ) || (t == RPU_HTRANS_SEQ);
  endfunction

  logic [7:0] valid_reg, valid_next;
  logic [7:0] addr_seen_reg, addr_seen_next;
  logic wr_pend_reg;
  logic [9:0] wr_ofs_reg;
  logic rd_pend_reg;
  logic [9:0] rd_ofs_reg;
  rpu_state_t state_reg, state_next;
  logic hreadyout_reg;
  logic [1:0] hresp_reg;
  logic patch_hit_reg;
  logic [2:0] patch_idx_reg;
  logic [ENTRIES*RPU_AW-1:0] addr_flat;
  logic [ENTRIES*RPU_DW-1:0] data_flat;
  logic [RPU_DW-1:0] mem_rd_word;

  // address-phase decode of the configuration slave
  wire acc_ok = hsel_i && hready_i && is_active(htrans_i);
  wire in_region = (haddr_i >= RPU_REG_BASE) && (haddr_i <= RPU_REG_LAST);
  wire [9:0] acc_ofs = haddr_i[9:0];
  wire is_pair = acc_ofs < RPU_OFS_VALID;
  wire is_ctrl = (acc_ofs == RPU_OFS_VALID) || (acc_ofs == RPU_OFS_CLEAR) || (acc_ofs == RPU_OFS_SET);
  // misaligned, non-word or unmapped accesses get a two-cycle error
  wire acc_bad = !in_region || haddr_i[1:0] != 2'b00 || hsize_i != 3'b010 || !(is_pair || is_ctrl);
  wire acc_good = acc_ok && !acc_bad && state_reg == RPU_ST_IDLE;
  wire acc_err = acc_ok && acc_bad && state_reg == RPU_ST_IDLE;

  // data-phase write decode: pair words at 8*n and 8*n+4
  wire [2:0] wr_idx = wr_ofs_reg[5:3];
  wire wr_is_data = wr_ofs_reg[2];
  wire wr_pair = wr_pend_reg && (wr_ofs_reg < RPU_OFS_VALID);
  wire wr_clear = wr_pend_reg && (wr_ofs_reg == RPU_OFS_CLEAR);
  wire wr_set = wr_pend_reg && (wr_ofs_reg == RPU_OFS_SET);
  wire [7:0] wr_onehot = 8'h01 << wr_idx;

  // valid and address-seen bookkeeping
  always_comb begin
    valid_next = valid_reg;
    addr_seen_next = addr_seen_reg;
    // RL8: clear strobe disables
    if (wr_clear) begin
      valid_next = valid_next & ~hwdata_i[7:0];
    end
    // RL9: set strobe re-enables
    if (wr_set) begin
      valid_next = valid_next | hwdata_i[7:0];
    end
    if (wr_pair && !wr_is_data) begin
      addr_seen_next = addr_seen_next | wr_onehot;
    end
    // RL4: auto valid after both writes; RL3 order assumed
    if (wr_pair && wr_is_data && addr_seen_reg[wr_idx]) begin
      valid_next = valid_next | wr_onehot;
      addr_seen_next = addr_seen_next & ~wr_onehot;
    end
  end

  // error response state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RPU_ST_IDLE: if (acc_err) state_next = RPU_ST_ERR1;
      RPU_ST_ERR1: state_next = RPU_ST_ERR2;
      RPU_ST_ERR2: state_next = RPU_ST_IDLE;
      default: state_next = RPU_ST_IDLE;
    endcase
  end

  // response flops follow the next state, so the bus sees them straight from a register
  wire ready_next = state_next != RPU_ST_ERR1;
  wire [1:0] resp_next = (state_next == RPU_ST_IDLE) ? RPU_HRESP_OKAY : RPU_HRESP_ERROR;

  // RL15: valid bits reset clear
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_reg <= RPU_VALID_RST;
      addr_seen_reg <= 8'h00;
      state_reg <= RPU_ST_IDLE;
      hreadyout_reg <= 1'b1;
      hresp_reg <= RPU_HRESP_OKAY;
    end else begin
      valid_reg <= valid_next;
      addr_seen_reg <= addr_seen_next;
      state_reg <= state_next;
      hreadyout_reg <= ready_next;
      hresp_reg <= resp_next;
    end
  end

  // RL11: capture address phase of good slave access
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_ofs_reg <= 10'h000;
      rd_ofs_reg <= 10'h000;
    end else begin
      wr_pend_reg <= acc_good && hwrite_i;
      rd_pend_reg <= acc_good && !hwrite_i;
      if (acc_good) begin
        wr_ofs_reg <= acc_ofs;
        rd_ofs_reg <= acc_ofs;
      end
    end
  end

  // RL2: eight address and data word pairs
  rpu_entry_mem #(
    .ENTRIES(ENTRIES),
    .W(RPU_DW)
  ) u_mem (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(wr_pair),
    .wr_data_sel_i(wr_is_data),
    .wr_idx_i(wr_idx),
    .wr_word_i(hwdata_i),
    .rd_data_sel_i(acc_ofs[2]),
    .rd_idx_i(acc_ofs[5:3]),
    .rd_word_o(mem_rd_word),
    .addr_flat_o(addr_flat),
    .data_flat_o(data_flat)
  );

  // slave read data and response; write-only words read zero
  wire [RPU_DW-1:0] rd_mux = (rd_ofs_reg < RPU_OFS_VALID) ? mem_rd_word :
                             (rd_ofs_reg == RPU_OFS_VALID) ? {24'h000000, valid_reg} : '0;
  assign hrdata_o = rd_pend_reg ? rd_mux : '0;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;

  // RL5: octal parallel compare
  logic [7:0] match_vec;
  for (genvar g = 0; g < 8; g++) begin : g_cmp
    assign match_vec[g] = valid_reg[g] && (addr_flat[g*RPU_AW +: RPU_AW] == {rom_haddr_i[31:2], 2'b00});
  end

  // RL13: only rom-region reads are candidates
  wire rom_region = rom_haddr_i <= RPU_ROM_LAST;
  wire rom_acc = rom_hsel_i && rom_hready_i && is_active(rom_htrans_i) && rom_region;

  // register the hit in the address phase so the data phase adds no wait
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      patch_hit_reg <= 1'b0;
      patch_idx_reg <= 3'h0;
    end else if (rom_hready_i) begin
      patch_hit_reg <= rom_acc && (match_vec != 8'h00);
      // RL7: highest entry wins
      patch_idx_reg <= top_index(match_vec);
    end
  end

  // RL1: rom data mux. RL6: substitute word. RL14: pass-through otherwise
  assign rom_rdata_o = patch_hit_reg ? data_flat[patch_idx_reg*RPU_DW +: RPU_DW] : rom_rdata_i;
  assign valid_flags_o = valid_reg;

  // RL10: single bus clock domain; contents lost on power-down, nothing retained here

  // assertions
  chk_clear_drops_bit: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL8
    wr_clear && !wr_set |=> (valid_reg & $past(hwdata_i[7:0])) == 8'h00)
    else $error("clear strobe left an entry enabled");
  chk_set_raises_bit: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL9
    wr_set |=> (valid_reg & $past(hwdata_i[7:0])) == $past(hwdata_i[7:0]))
    else $error("set strobe did not enable entry");
  // error response in two steps: stall with error, then release with error
  sequence s_err_stall;
    !hreadyout_o && hresp_o == RPU_HRESP_ERROR;
  endsequence
  sequence s_err_release;
    hreadyout_o && hresp_o == RPU_HRESP_ERROR;
  endsequence
  chk_auto_valid: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL4
    (wr_pair && wr_is_data && addr_seen_reg[wr_idx] && !wr_clear) |=> valid_reg[$past(wr_idx)])
    else $error("entry not valid after both words written");
  chk_pass_through: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL14
    !patch_hit_reg |-> rom_rdata_o == rom_rdata_i)
    else $error("rom data altered without a hit");
  chk_substitute: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL6
    rom_hready_i && rom_acc && match_vec != 8'h00 |=> patch_hit_reg &&
      (($past(match_vec) >> patch_idx_reg) == 8'h01) && rom_rdata_o == data_flat[patch_idx_reg*RPU_DW +: RPU_DW])
    else $error("matching entry word not substituted");
  chk_top_priority: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL7
    rom_hready_i && rom_acc && match_vec[7] |=> patch_hit_reg && patch_idx_reg == 3'h7)
    else $error("entry seven did not win");
  chk_out_of_rom: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL13
    rom_hready_i && !rom_region |=> !patch_hit_reg)
    else $error("patch applied outside rom region");
  chk_parallel_cmp: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL5
    rom_hready_i && rom_acc && match_vec == 8'h00 |=> !patch_hit_reg)
    else $error("hit without any matching entry");
  chk_zero_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL15
    (wr_set || wr_clear) && hwdata_i[7:0] == 8'h00 && !wr_pair |=> $stable(valid_reg))
    else $error("zero write changed valid bits");
  chk_err_two_cycle: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL11
    acc_err |=> s_err_stall ##1 s_err_release)
    else $error("bad access not given a two-cycle error");

  // set and clear each move bits one way only
  chk_set_no_drop: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL9
    wr_set |=> ($past(valid_reg) & ~valid_reg) == 8'h00)
    else $error("set strobe disabled an entry");
  chk_clear_no_raise: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL8
    wr_clear |=> (valid_reg & ~$past(valid_reg)) == 8'h00)
    else $error("clear strobe enabled an entry");

  // bus side: zero-wait good accesses, no effect from refused ones
  chk_good_no_wait: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL11
    acc_good |=> hreadyout_o && hresp_o == RPU_HRESP_OKAY)
    else $error("good access stalled or refused");
  chk_err_no_effect: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL11
    acc_err |=> !wr_pend_reg && !rd_pend_reg)
    else $error("refused access reached a register");
  chk_ctrl_read_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL8
    rd_pend_reg && (rd_ofs_reg == RPU_OFS_CLEAR || rd_ofs_reg == RPU_OFS_SET) |-> hrdata_o == 32'h0000_0000)
    else $error("write-only control word read back nonzero");
  chk_valid_read: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL11
    rd_pend_reg && rd_ofs_reg == RPU_OFS_VALID |-> hrdata_o == {24'h000000, valid_reg})
    else $error("valid word read back wrong");
  chk_pair_read: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL2
    rd_pend_reg && rd_ofs_reg < RPU_OFS_VALID |->
      hrdata_o == (rd_ofs_reg[2] ? data_flat[rd_ofs_reg[5:3]*RPU_DW +: RPU_DW] :
                                   addr_flat[rd_ofs_reg[5:3]*RPU_AW +: RPU_AW]))
    else $error("pair read returned the wrong word");

  // entry words land where the pair offset points; only a data word after its address validates
  chk_addr_lands: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL2
    wr_pair && !wr_is_data |=> addr_flat[$past(wr_idx)*RPU_AW +: RPU_AW] == $past(hwdata_i))
    else $error("match address not stored");
  chk_data_lands: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL2
    wr_pair && wr_is_data |=> data_flat[$past(wr_idx)*RPU_DW +: RPU_DW] == $past(hwdata_i))
    else $error("replacement word not stored");
  chk_addr_marked: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL4
    wr_pair && !wr_is_data |=> addr_seen_reg[$past(wr_idx)])
    else $error("address write not remembered");
  chk_data_alone: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL4
    wr_pair && wr_is_data && !addr_seen_reg[wr_idx] && !valid_reg[wr_idx] |=> !valid_reg[$past(wr_idx)])
    else $error("data word alone enabled an entry");
  chk_valid_quiet: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL15
    !wr_pend_reg |=> $stable(valid_reg))
    else $error("valid bits moved without a write");

  // rom path: a stalled bus holds the hit, an idle or foreign cycle clears it
  chk_rom_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL6
    !rom_hready_i |=> $stable(patch_hit_reg) && $stable(patch_idx_reg))
    else $error("patch hit lost during a bus stall");
  chk_idle_no_hit: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // RL14
    rom_hready_i && !rom_acc |=> !patch_hit_reg)
    else $error("patch hit without a rom access");
endmodule
